//--- thermal_mon_defines.svh
// constants for the die thermal threshold monitor
`ifndef THERMAL_MON_DEFINES_SVH
`define THERMAL_MON_DEFINES_SVH
// ==========================================
// timing
`define TM_CLK_NS 50
`define TM_DEBOUNCE_NS 10000
`define TM_WINDOW_NS 450000
`define TM_INTERVAL_NS 3000000
`define TM_DB_CYC ((`TM_DEBOUNCE_NS + `TM_CLK_NS - 1) / `TM_CLK_NS)
`define TM_WINDOW_CYC (`TM_WINDOW_NS / `TM_CLK_NS)
`define TM_INTERVAL_CYC (`TM_INTERVAL_NS / `TM_CLK_NS)
`define TM_CNT_W 16
// ==========================================
// channels: six warnings, then shutdown
`define TM_NWARN 6
`define TM_NCH 7
`define TM_SD_CH 6
`define TM_CH80 0
`define TM_CH95 1
`define TM_CH110 2
`define TM_CH125 3
`define TM_CH140 4
`define TM_CH155 5
// ==========================================
// register map
`define TM_OFF_CTRL 8'h00
`define TM_OFF_FLAG 8'h04
`define TM_OFF_MASK 8'h08
`define TM_OFF_STAT 8'h0C
`define TM_CTRL_EN 0
`define TM_CTRL_AON 1
`define TM_CTRL_RST 2'h3
`define TM_MASK_RST 7'h00
`define TM_STAT_PWR 8
`define TM_STAT_SD 9
`define TM_STAT_SAMP 10
`endif

//--- thermal_mon_pkg.sv
// types for the die thermal threshold monitor
package thermal_mon_pkg;
    typedef enum logic [1:0] {
        ST_OFF = 2'b00,
        ST_CONT = 2'b01,
        ST_WIN = 2'b10,
        ST_GAP = 2'b11
    } seq_state_t;
    typedef logic [6:0] chan_vec_t;
endpackage : thermal_mon_pkg

//--- thermal_seq_if.sv
// sensor power sequencer to core signals
`timescale 1ns/1ps
`default_nettype none
interface thermal_seq_if;
    logic power;
    logic sampling;
    modport seq (output power, output sampling);
    modport core (input power, input sampling);
endinterface : thermal_seq_if
`default_nettype wire

//--- thermal_debounce.sv
// one debounced threshold channel with falling hysteresis
`timescale 1ns/1ps
`default_nettype none
`include "thermal_mon_defines.svh"
module thermal_debounce #(
    parameter int DB_CYC = `TM_DB_CYC
) (
    input wire logic ref_clk,
    input wire logic rstn,
    input wire logic sample,
    input wire logic clear,
    input wire logic above_thr,
    input wire logic above_rel,
    output logic sense_r
);
    logic [`TM_CNT_W-1:0] cnt_r, cnt_nxt;
    logic sense_nxt;
    logic target;

    // ==========================================
    // debounce
    always_comb begin
        // once set, only the release comparator or clear can drop it
        target = sense_r ? above_rel : above_thr;
        sense_nxt = sense_r;
        cnt_nxt = '0;
        if (clear) begin
            sense_nxt = 1'b0;
        end else if (sample && (target != sense_r)) begin
            if (cnt_r == `TM_CNT_W'(DB_CYC - 1)) begin
                sense_nxt = target;
            end else begin
                cnt_nxt = cnt_r + `TM_CNT_W'(1);
            end
        end
    end

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            sense_r <= 1'b0;
            cnt_r <= '0;
        end else begin
            sense_r <= sense_nxt;
            cnt_r <= cnt_nxt;
        end
    end

    // ==========================================
    // checks
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rstn);

    AST_DB_TIME: assert property ($changed(sense_r) && !$past(clear) |->
        $past(cnt_r) == `TM_CNT_W'(DB_CYC - 1)) else $error("sense moved before debounce");
    AST_DB_HOLD: assert property (!sample && !clear |=> $stable(sense_r))
        else $error("sense moved outside window");
    AST_DB_HYS: assert property (sense_r && above_rel && !clear |=> sense_r)
        else $error("sense released above release point");
endmodule : thermal_debounce
`default_nettype wire

//--- thermal_seq.sv
// sensor power sequencer: continuous or sampling bursts
`timescale 1ns/1ps
`default_nettype none
`include "thermal_mon_defines.svh"
module thermal_seq #(
    parameter int WINDOW_CYC = `TM_WINDOW_CYC,
    parameter int INTERVAL_CYC = `TM_INTERVAL_CYC
) (
    input wire logic ref_clk,
    input wire logic rstn,
    input wire logic enable,
    input wire logic always_on,
    input wire logic run_state,
    thermal_seq_if.seq sq
);
    thermal_mon_pkg::seq_state_t state_r, state_nxt;
    logic [`TM_CNT_W-1:0] cnt_r, cnt_nxt;
    logic power_r, power_nxt;
    logic cont;

    // ==========================================
    // state machine
    always_comb begin
        // standby ignores always-on
        cont = run_state && always_on;
        state_nxt = state_r;
        cnt_nxt = cnt_r + `TM_CNT_W'(1);
        unique case (state_r)
            thermal_mon_pkg::ST_OFF: begin
                cnt_nxt = '0;
                if (enable) begin
                    state_nxt = cont ? thermal_mon_pkg::ST_CONT : thermal_mon_pkg::ST_WIN;
                end
            end
            thermal_mon_pkg::ST_CONT: begin
                cnt_nxt = '0;
                if (!cont) begin
                    state_nxt = thermal_mon_pkg::ST_WIN;
                end
            end
            thermal_mon_pkg::ST_WIN: begin
                if (cont) begin
                    state_nxt = thermal_mon_pkg::ST_CONT;
                end else if (cnt_r == `TM_CNT_W'(WINDOW_CYC - 1)) begin
                    state_nxt = thermal_mon_pkg::ST_GAP;
                end
            end
            thermal_mon_pkg::ST_GAP: begin
                if (cont) begin
                    state_nxt = thermal_mon_pkg::ST_CONT;
                end else if (cnt_r == `TM_CNT_W'(INTERVAL_CYC - 1)) begin
                    state_nxt = thermal_mon_pkg::ST_WIN;
                    cnt_nxt = '0;
                end
            end
        endcase
        if (!enable) begin
            state_nxt = thermal_mon_pkg::ST_OFF;
        end
        power_nxt = (state_nxt == thermal_mon_pkg::ST_CONT) ||
                    (state_nxt == thermal_mon_pkg::ST_WIN);
    end

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            state_r <= thermal_mon_pkg::ST_OFF;
            cnt_r <= '0;
            power_r <= 1'b0;
        end else begin
            state_r <= state_nxt;
            cnt_r <= cnt_nxt;
            power_r <= power_nxt;
        end
    end

    assign sq.power = power_r;
    assign sq.sampling = (state_r == thermal_mon_pkg::ST_WIN) || (state_r == thermal_mon_pkg::ST_GAP);

    // ==========================================
    // checks
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rstn);

    AST_EN_OFF: assert property (!enable |=> !power_r)
        else $error("sensor powered while disabled");
    AST_AON: assert property (enable && run_state && always_on ##1
        enable && run_state && always_on |=> power_r) else $error("always-on gap");
    AST_STBY: assert property (!run_state |=> state_r != thermal_mon_pkg::ST_CONT)
        else $error("continuous power in standby");
    AST_WIN_LEN: assert property (state_r == thermal_mon_pkg::ST_WIN |->
        cnt_r < `TM_CNT_W'(WINDOW_CYC)) else $error("window too long");
    AST_PERIOD: assert property (state_r == thermal_mon_pkg::ST_GAP && cont == 1'b0 && enable
        && cnt_r == `TM_CNT_W'(INTERVAL_CYC - 1) |=> power_r) else $error("window missed");
endmodule : thermal_seq
`default_nettype wire

//--- thermal_mon.sv
// top of the die thermal threshold monitor with apb registers
//
// Implementation choices: the APB slave port and the address map.
`timescale 1ns/1ps
`default_nettype none
`include "thermal_mon_defines.svh"
// How it works
// - Only the centre-of-die comparators feed warnings and shutdown; no other sensor enters.
// - Six warning channels (80 to 155 degrees) each own a flag, a sense bit and a mask bit.
// - A sense bit rising sets that channel's interrupt flag.
// - A set warning sense bit drops only once the 5-degree-lower release comparator falls or the enable bit is cleared.
// - A debounced crossing of the shutdown threshold raises the shutdown output.
// - Shutdown stays raised until the shutdown release comparator has fallen or the enable bit is cleared.
// - Each comparison must stand for the debounce time before a sense bit changes.
// - With the enable bit clear the sensor is unpowered, with it set it is powered continuously or in sampling windows.
// - Run state with always-on set keeps the sensor powered without pause.
// - Run state with always-on clear powers the sensor in 450 us windows every 3.0 ms.
// - Standby uses sampling only, and only with the enable bit set.
// - Clearing always-on moves to sampling, setting it in run state returns to continuous power.
// - A set flag with its mask clear pulls the active-low host interrupt low.
module thermal_mon #(
    parameter int SAMPLE_WINDOW_CYC = `TM_WINDOW_CYC,
    parameter int SAMPLE_INTERVAL_CYC = `TM_INTERVAL_CYC
) (
    input wire logic ref_clk,
    input wire logic rstn,
    input wire logic run_state,
    input wire logic [5:0] warn_above_thr,
    input wire logic [5:0] warn_above_rel,
    input wire logic sd_above_thr,
    input wire logic sd_above_rel,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic host_irq_n,
    output logic thermal_shutdown,
    output logic sensor_power
);
    thermal_seq_if sq ();

    // ==========================================
    // state
    logic [1:0] ctrl_r, ctrl_nxt;
    thermal_mon_pkg::chan_vec_t flag_r, flag_nxt;
    thermal_mon_pkg::chan_vec_t mask_r, mask_nxt;
    thermal_mon_pkg::chan_vec_t sense_d_r;
    thermal_mon_pkg::chan_vec_t warn_sense_bit;
    thermal_mon_pkg::chan_vec_t sense_rise;
    thermal_mon_pkg::chan_vec_t above_thr;
    thermal_mon_pkg::chan_vec_t above_rel;
    logic [31:0] rdata_nxt;
    logic ready_nxt;
    logic err_nxt;
    logic irq_n_nxt;
    logic sd_nxt;
    logic pwr_nxt;
    logic take;
    logic monitor_enable;
    logic monitor_always_on;

    assign monitor_enable = ctrl_r[`TM_CTRL_EN];
    assign monitor_always_on = ctrl_r[`TM_CTRL_AON];
    // centre sensor only; the other sensors never reach this block
    assign above_thr = {sd_above_thr, warn_above_thr};
    assign above_rel = {sd_above_rel, warn_above_rel};

    // ==========================================
    // sequencer
    thermal_seq #(
        .WINDOW_CYC(SAMPLE_WINDOW_CYC),
        .INTERVAL_CYC(SAMPLE_INTERVAL_CYC)
    ) u_seq (
        .ref_clk(ref_clk),
        .rstn(rstn),
        .enable(monitor_enable),
        .always_on(monitor_always_on),
        .run_state(run_state),
        .sq(sq)
    );

    // ==========================================
    // debounced channels
    genvar gi;
    generate
        for (gi = 0; gi < `TM_NCH; gi++) begin : g_ch
            thermal_debounce #(
                .DB_CYC(`TM_DB_CYC)
            ) u_db (
                .ref_clk(ref_clk),
                .rstn(rstn),
                .sample(sq.power),
                .clear(!monitor_enable),
                .above_thr(above_thr[gi]),
                .above_rel(above_rel[gi]),
                .sense_r(warn_sense_bit[gi])
            );
        end
    endgenerate

    assign sense_rise = warn_sense_bit & ~sense_d_r;

    // ==========================================
    // per-threshold bit views
    // names only; the vectors above remain the storage
    logic warn80_irq_flag;
    logic warn80_sense;
    logic warn80_irq_mask;
    logic warn95_irq_flag;
    logic warn95_sense;
    logic warn95_irq_mask;
    logic warn110_irq_flag;
    logic warn110_sense;
    logic warn110_irq_mask;
    logic warn125_irq_flag;
    logic warn125_sense;
    logic warn125_irq_mask;
    logic warn140_irq_flag;
    logic warn140_sense;
    logic warn140_irq_mask;
    logic warn155_irq_flag;
    logic warn155_sense;
    logic warn155_irq_mask;
    assign warn80_irq_flag = flag_r[`TM_CH80];
    assign warn80_sense = warn_sense_bit[`TM_CH80];
    assign warn80_irq_mask = mask_r[`TM_CH80];
    assign warn95_irq_flag = flag_r[`TM_CH95];
    assign warn95_sense = warn_sense_bit[`TM_CH95];
    assign warn95_irq_mask = mask_r[`TM_CH95];
    assign warn110_irq_flag = flag_r[`TM_CH110];
    assign warn110_sense = warn_sense_bit[`TM_CH110];
    assign warn110_irq_mask = mask_r[`TM_CH110];
    assign warn125_irq_flag = flag_r[`TM_CH125];
    assign warn125_sense = warn_sense_bit[`TM_CH125];
    assign warn125_irq_mask = mask_r[`TM_CH125];
    assign warn140_irq_flag = flag_r[`TM_CH140];
    assign warn140_sense = warn_sense_bit[`TM_CH140];
    assign warn140_irq_mask = mask_r[`TM_CH140];
    assign warn155_irq_flag = flag_r[`TM_CH155];
    assign warn155_sense = warn_sense_bit[`TM_CH155];
    assign warn155_irq_mask = mask_r[`TM_CH155];

    // ==========================================
    // registers and apb
    always_comb begin
        ctrl_nxt = ctrl_r;
        flag_nxt = flag_r;
        mask_nxt = mask_r;
        rdata_nxt = 32'h0000_0000;
        err_nxt = 1'b0;
        // one wait state: pready rises in the second access cycle
        ready_nxt = psel && penable && !pready;
        take = psel && penable && pready;
        if (ready_nxt) begin
            unique case (paddr)
                `TM_OFF_CTRL: rdata_nxt[1:0] = ctrl_r;
                `TM_OFF_FLAG: begin
                    rdata_nxt[`TM_CH80] = warn80_irq_flag;
                    rdata_nxt[`TM_CH95] = warn95_irq_flag;
                    rdata_nxt[`TM_CH110] = warn110_irq_flag;
                    rdata_nxt[`TM_CH125] = warn125_irq_flag;
                    rdata_nxt[`TM_CH140] = warn140_irq_flag;
                    rdata_nxt[`TM_CH155] = warn155_irq_flag;
                    rdata_nxt[`TM_SD_CH] = flag_r[`TM_SD_CH];
                end
                `TM_OFF_MASK: begin
                    rdata_nxt[`TM_CH80] = warn80_irq_mask;
                    rdata_nxt[`TM_CH95] = warn95_irq_mask;
                    rdata_nxt[`TM_CH110] = warn110_irq_mask;
                    rdata_nxt[`TM_CH125] = warn125_irq_mask;
                    rdata_nxt[`TM_CH140] = warn140_irq_mask;
                    rdata_nxt[`TM_CH155] = warn155_irq_mask;
                    rdata_nxt[`TM_SD_CH] = mask_r[`TM_SD_CH];
                end
                `TM_OFF_STAT: begin
                    rdata_nxt[`TM_CH80] = warn80_sense;
                    rdata_nxt[`TM_CH95] = warn95_sense;
                    rdata_nxt[`TM_CH110] = warn110_sense;
                    rdata_nxt[`TM_CH125] = warn125_sense;
                    rdata_nxt[`TM_CH140] = warn140_sense;
                    rdata_nxt[`TM_CH155] = warn155_sense;
                    rdata_nxt[`TM_SD_CH] = warn_sense_bit[`TM_SD_CH];
                    rdata_nxt[`TM_STAT_PWR] = sq.power;
                    rdata_nxt[`TM_STAT_SD] = thermal_shutdown;
                    rdata_nxt[`TM_STAT_SAMP] = sq.sampling;
                end
                default: err_nxt = 1'b1;
            endcase
        end
        if (take && pwrite) begin
            unique case (paddr)
                `TM_OFF_CTRL: ctrl_nxt = pwdata[1:0];
                `TM_OFF_FLAG: flag_nxt = flag_r & ~pwdata[`TM_NCH-1:0];
                `TM_OFF_MASK: mask_nxt = pwdata[`TM_NCH-1:0];
                default: ctrl_nxt = ctrl_r;
            endcase
        end
        // a rise in the clearing cycle still lands
        flag_nxt = flag_nxt | sense_rise;
        irq_n_nxt = ~|(flag_nxt & ~mask_nxt);
        sd_nxt = warn_sense_bit[`TM_SD_CH];
        pwr_nxt = sq.power;
    end

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            ctrl_r <= `TM_CTRL_RST;
            flag_r <= '0;
            mask_r <= `TM_MASK_RST;
            sense_d_r <= '0;
            prdata <= 32'h0000_0000;
            pready <= 1'b0;
            pslverr <= 1'b0;
            host_irq_n <= 1'b1;
            thermal_shutdown <= 1'b0;
            sensor_power <= 1'b0;
        end else begin
            ctrl_r <= ctrl_nxt;
            flag_r <= flag_nxt;
            mask_r <= mask_nxt;
            sense_d_r <= warn_sense_bit;
            prdata <= rdata_nxt;
            pready <= ready_nxt;
            pslverr <= err_nxt;
            host_irq_n <= irq_n_nxt;
            thermal_shutdown <= sd_nxt;
            sensor_power <= pwr_nxt;
        end
    end

    // ==========================================
    // checks
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rstn);

    sequence s_rise;
        |sense_rise;
    endsequence
    sequence s_flag_write;
        take && pwrite && (paddr == `TM_OFF_FLAG);
    endsequence
    sequence s_ctrl_write;
        take && pwrite && (paddr == `TM_OFF_CTRL);
    endsequence
    sequence s_mask_write;
        take && pwrite && (paddr == `TM_OFF_MASK);
    endsequence
    // the slave answers in the second access cycle
    sequence s_access;
        psel && penable && !pready;
    endsequence
    sequence s_sd_rise;
        $rose(warn_sense_bit[`TM_SD_CH]);
    endsequence
    sequence s_disabled;
        !monitor_enable;
    endsequence
    sequence s_between_windows;
        monitor_enable && !sq.power;
    endsequence

    AST_FLAG_SET: assert property (s_rise |=> (flag_r & $past(sense_rise)) == $past(sense_rise))
        else $error("rise did not set flag");
    AST_FLAG_STICKY: assert property (!(take && pwrite && (paddr == `TM_OFF_FLAG)) |=>
        (flag_r & $past(flag_r)) == $past(flag_r)) else $error("flag dropped without a write");
    AST_FLAG_CLR: assert property (s_flag_write |=>
        (flag_r & ~$past(sense_rise)) ==
        ($past(flag_r) & ~$past(pwdata[`TM_NCH-1:0]) & ~$past(sense_rise)))
        else $error("flag write did not clear");
    AST_CTRL_WRITE: assert property (s_ctrl_write |=>
        ctrl_r == $past(pwdata[`TM_CTRL_AON:`TM_CTRL_EN])) else $error("control write lost");
    AST_MASK_WRITE: assert property (s_mask_write |=>
        mask_r == $past(pwdata[`TM_NCH-1:0])) else $error("mask write lost");

    AST_APB_WAIT: assert property (s_access |=> pready)
        else $error("no answer after access cycle");
    AST_APB_PULSE: assert property (pready |=> !pready)
        else $error("ready held too long");
    AST_APB_ERR: assert property (pslverr |-> pready)
        else $error("error without ready");

    AST_IRQ_LEVEL: assert property (host_irq_n == !(|(flag_r & ~mask_r)))
        else $error("interrupt level wrong");
    AST_MASK_QUIET: assert property ((flag_r & ~mask_r) == '0 |-> host_irq_n)
        else $error("masked flag drives interrupt");
    AST_SD_SET: assert property (s_sd_rise |=> thermal_shutdown)
        else $error("shutdown not raised");
    AST_SD_HOLD: assert property (thermal_shutdown && warn_sense_bit[`TM_SD_CH] |=>
        thermal_shutdown) else $error("shutdown dropped early");
    AST_SD_RELEASE: assert property ($fell(thermal_shutdown) |->
        !$past(warn_sense_bit[`TM_SD_CH])) else $error("shutdown dropped while sensed");

    AST_EN_CLEAR: assert property (s_disabled |=> warn_sense_bit == '0)
        else $error("sense kept while disabled");
    AST_GAP_HOLD: assert property (s_between_windows |=> $stable(warn_sense_bit))
        else $error("sense moved between windows");
    AST_PWR_OUT: assert property (sensor_power == $past(sq.power))
        else $error("sensor power output wrong");
endmodule : thermal_mon
`default_nettype wire

//--- thermal_sensor_model.sv
// comparator model of the centre-of-die temperature sensor
`timescale 1ns/1ps
`default_nettype none
module thermal_sensor_model #(
    parameter int SD_HYS = 10
) (
    input wire logic ref_clk,
    input wire logic power,
    input wire logic [7:0] temp,
    output logic [5:0] above_thr,
    output logic [5:0] above_rel,
    output logic sd_thr,
    output logic sd_rel
);
    logic junk_r = 1'b0;
    // ==========================================
    // comparators
    // unpowered outputs toggle every cycle so no debounce can ever complete on them
    always @(posedge ref_clk) begin
        junk_r <= ~junk_r;
    end
    always_comb begin
        for (int i = 0; i < 6; i++) begin
            above_thr[i] = power ? (int'(temp) >= 80 + 15 * i) : junk_r;
            above_rel[i] = power ? (int'(temp) >= 75 + 15 * i) : ~junk_r;
        end
        sd_thr = power ? (int'(temp) >= 165) : junk_r;
        sd_rel = power ? (int'(temp) >= 165 - SD_HYS) : ~junk_r;
    end
endmodule : thermal_sensor_model
`default_nettype wire

//--- tb_die_thermal_threshold_monitor.sv
// self-checking testbench of the die thermal threshold monitor
`timescale 1ns/1ps
`default_nettype none
`include "thermal_mon_defines.svh"
module tb_die_thermal_threshold_monitor;
    localparam int WIN = 300;
    localparam int INTV = 1000;
    localparam int DB = 200;
    logic ref_clk = 1'b0;
    logic rstn, run_state, psel, penable, pwrite, pready, pslverr;
    logic host_irq_n, thermal_shutdown, sensor_power, sd_thr, sd_rel, err;
    logic [7:0] paddr, temp;
    logic [31:0] pwdata, prdata, rd;
    logic [5:0] thr, rel;
    logic [2:0] ctrl_tab [5] = '{3'h7, 3'h5, 3'h3, 3'h1, 3'h6};
    int pwr_tab [5] = '{INTV, WIN, WIN, WIN, 0};
    int fails = 0;
    int check_count = 0;
    int cyc = 0;
    int cnt;
    // ==========================================
    // clock, timeout, instances
    always #25 ref_clk = ~ref_clk;
    always @(posedge ref_clk) begin
        cyc <= cyc + 1;
        if (cyc == 40000) begin
            fails++;
            end_sim();
        end
    end
    thermal_mon #(.SAMPLE_WINDOW_CYC(WIN), .SAMPLE_INTERVAL_CYC(INTV)) dut_u (
        .ref_clk(ref_clk), .rstn(rstn), .run_state(run_state),
        .warn_above_thr(thr), .warn_above_rel(rel), .sd_above_thr(sd_thr),
        .sd_above_rel(sd_rel), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .host_irq_n(host_irq_n), .thermal_shutdown(thermal_shutdown),
        .sensor_power(sensor_power)
    );
    thermal_sensor_model sensor_u (
        .ref_clk(ref_clk), .power(sensor_power), .temp(temp), .above_thr(thr),
        .above_rel(rel), .sd_thr(sd_thr), .sd_rel(sd_rel)
    );
    // ==========================================
    // tasks
    task automatic end_sim;
        $display("checks %0d mismatches %0d", check_count, fails);
        if (fails == 0 && check_count > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask : end_sim
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            fails++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    // waits for pready; only the global timeout ends a hang
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge ref_clk);
        penable <= 1'b1;
        @(posedge ref_clk);
        while (pready !== 1'b1) begin
            @(posedge ref_clk);
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge ref_clk);
    endtask : apb
    task automatic rchk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        check(rd & m, e);
    endtask : rchk
    task automatic heat(input logic [7:0] t);
        temp <= t;
        repeat (DB + 50) @(posedge ref_clk);
    endtask : heat
    task automatic wait_pwr(input logic v);
        int n;
        n = 0;
        while (sensor_power !== v && n < 2 * INTV) begin
            @(posedge ref_clk);
            n++;
        end
    endtask : wait_pwr
    // ==========================================
    // tests
    initial begin
        rstn = 1'b0;
        run_state = 1'b1;
        {psel, penable, pwrite} = 3'h0;
        paddr = 8'h00;
        pwdata = 32'h0;
        temp = 8'h19;
        repeat (2) @(posedge ref_clk);
        rstn <= 1'b1;
        @(posedge ref_clk);
        rchk(`TM_OFF_CTRL, 32'h3, 32'h3);
        rchk(`TM_OFF_MASK, 32'h3F, 32'h0);
        rchk(`TM_OFF_FLAG, 32'h3F, 32'h0);
        apb(1'b0, 8'h40, 32'h0);
        check(err, 1'b1);
        check(host_irq_n, 1'b1);
        $display("test reset done");
        temp <= 8'h64;
        repeat (DB - 50) @(posedge ref_clk);
        rchk(`TM_OFF_STAT, 32'h3F, 32'h0);
        repeat (100) @(posedge ref_clk);
        rchk(`TM_OFF_STAT, 32'h3F, 32'h03);
        rchk(`TM_OFF_FLAG, 32'h3F, 32'h03);
        check(host_irq_n, 1'b0);
        heat(8'h73);
        heat(8'h6B);
        rchk(`TM_OFF_STAT, 32'h3F, 32'h07);
        heat(8'h68);
        rchk(`TM_OFF_STAT, 32'h3F, 32'h03);
        rchk(`TM_OFF_FLAG, 32'h3F, 32'h07);
        $display("test thresholds done");
        apb(1'b1, `TM_OFF_FLAG, 32'h0);
        rchk(`TM_OFF_FLAG, 32'h3F, 32'h07);
        apb(1'b1, `TM_OFF_FLAG, 32'h04);
        rchk(`TM_OFF_FLAG, 32'h3F, 32'h03);
        apb(1'b1, `TM_OFF_MASK, 32'h7F);
        repeat (2) @(posedge ref_clk);
        check(host_irq_n, 1'b1);
        apb(1'b1, `TM_OFF_MASK, 32'h7E);
        repeat (2) @(posedge ref_clk);
        check(host_irq_n, 1'b0);
        apb(1'b1, `TM_OFF_FLAG, 32'h7F);
        apb(1'b1, `TM_OFF_MASK, 32'h00);
        repeat (2) @(posedge ref_clk);
        check(host_irq_n, 1'b1);
        $display("test flags done");
        heat(8'hAA);
        check(thermal_shutdown, 1'b1);
        rchk(`TM_OFF_STAT, 32'h1 << `TM_STAT_SD, 32'h1 << `TM_STAT_SD);
        heat(8'h9E);
        check(thermal_shutdown, 1'b1);
        heat(8'h96);
        check(thermal_shutdown, 1'b0);
        heat(8'h19);
        apb(1'b1, `TM_OFF_FLAG, 32'h7F);
        $display("test shutdown done");
        for (int k = 0; k < 5; k++) begin
            run_state <= ctrl_tab[k][2];
            apb(1'b1, `TM_OFF_CTRL, {30'h0, ctrl_tab[k][1:0]});
            repeat (INTV) @(posedge ref_clk);
            cnt = 0;
            repeat (INTV) begin
                @(posedge ref_clk);
                if (sensor_power === 1'b1) cnt++;
            end
            check(cnt, pwr_tab[k]);
        end
        $display("test power modes done");
        run_state <= 1'b1;
        apb(1'b1, `TM_OFF_CTRL, 32'h1);
        wait_pwr(1'b1);
        wait_pwr(1'b0);
        heat(8'h64);
        rchk(`TM_OFF_STAT, 32'h73F, 32'h400);
        repeat (INTV) @(posedge ref_clk);
        rchk(`TM_OFF_STAT, 32'h73F, 32'h403);
        $display("test sampling capture done");
        end_sim();
    end
endmodule : tb_die_thermal_threshold_monitor
`default_nettype wire
